//--- verilog/ovr_pkg.sv
/*
  Constants, field layouts and types for the over-voltage fault retry block.
  Assumes a command decoder outside that turns management bus transfers into
  single-cycle command strobes on the core clock.
*/
package ovr_pkg;

    // Command codes of the management registers
    localparam logic [7:0] CMD_OV_RESPONSE = 8'h41; // Fault action setting, byte
    localparam logic [7:0] CMD_OV_WARN = 8'h42; // Warning threshold, word
    localparam logic [7:0] CMD_UNIT = 8'hd2; // Delay time unit setting
    localparam logic [7:0] CMD_OV_STATUS = 8'he0; // Read-only status byte

    // Reset values
    localparam logic [7:0] RST_RESPONSE = 8'h80; // Shut down, no retry, 1 unit
    localparam logic [15:0] RST_WARN = 16'hffff; // Warning never trips
    localparam logic [15:0] RST_UNIT = 16'h0000; // One base unit

    // Field positions of the fault action setting
    localparam int ACT_LSB = 6; // Action bits 7:6
    localparam int RETRY_LSB = 3; // Retry bits 5:3
    localparam int DELAY_LSB = 0; // Delay code bits 2:0

    // Action codes
    localparam logic [1:0] ACT_IGNORE = 2'h0;
    localparam logic [1:0] ACT_RUN_THEN_RETRY = 2'h1;
    localparam logic [1:0] ACT_SHUTDOWN_RETRY = 2'h2;
    localparam logic [1:0] ACT_OFF_WHILE_FAULT = 2'h3;

    // Retry codes with special meaning
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_ENDLESS = 3'h7;

    // Status byte bit positions
    localparam int STAT_WARN_BIT = 0;
    localparam int STAT_LATCH_BIT = 1;
    localparam int STAT_OFF_BIT = 2;

    // Timing: one base unit of delay, scaled by the unit register value + 1
    localparam int CLK_PERIOD_PS = 25000; // 40 MHz core clock
    localparam int UNIT_BASE_NS = 1000; // Base time unit in ns
    localparam int UNIT_BASE_CYCLES = (UNIT_BASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // Decoded fault action setting
    typedef struct packed {
        logic [1:0] action; // Response action
        logic [2:0] retries; // Retry setting
        logic [2:0] delay; // Delay code, 2^code units
    } ovr_resp_type;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_RUN = 3'b000, // Normal operation
        ST_GRACE = 3'b001, // Running on through the delay after detection
        ST_WAIT = 3'b010, // Output off, timing toward next attempt
        ST_TRY = 3'b011, // Restart attempt in progress
        ST_LATCH = 3'b100, // Off until fault cleared
        ST_HOLD = 3'b101 // Off while fault persists
    } ovr_state_type;

endpackage

//--- verilog/ovr_fault_retry.sv
/*
  Over-voltage fault response sequencer with its management registers:
  fault action setting, warning threshold, delay unit and a status byte.
  Assumes a command port decoded from the management bus on core_clk, a
  fault comparator pin from the analog side, and a measured output word
  from an ADC that already runs on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Retry codes 1..6 give exactly that many restarts
// - All restarts failed: output off until cleared
// - Code 111 retries endlessly until off or other fault
// - Attempts spaced start to start by delay
// - Delay code selects 1 to 128 units
// - Unit length taken from register 0xD2
// - Warning threshold word at 0x42, read/write
// - Action bits pick ignore, run-on, shutdown, hold-off
// - Retry code 000: no restart, stay off
module ovr_fault_retry
    import ovr_pkg::*;
(
    input wire logic core_clk, // Core clock, 40 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic cmd_valid, // Command strobe, one cycle
    input wire logic cmd_write, // 1 write, 0 read
    input wire logic [7:0] cmd_code, // Command code
    input wire logic [15:0] cmd_wdata, // Write data, bytes in low bits
    output logic cmd_ack_q, // Answer strobe, one cycle
    output logic [15:0] cmd_rdata_q, // Read data, valid with ack
    input wire logic ov_fault_pin, // Over-voltage comparator, async
    input wire logic ctrl_pin, // Remote on/off pin, async, high = on
    input wire logic op_on, // Operation command on, core domain
    input wire logic clear_faults, // Clear latched fault, one cycle
    input wire logic other_fault, // Another fault latches off during retry wait or attempt
    input wire logic [15:0] vout_meas, // Measured output, core domain
    output logic output_en_q, // Power stage enable
    output logic ov_latched_q, // Latched-off fault indication
    output logic ov_warn_q // Over-voltage warning level
);

    // Synchronisers for the two pin inputs
    logic [1:0] fault_sync_q;
    logic [1:0] ctrl_sync_q;

    // Register file
    ovr_resp_type resp_q, resp_d; // Fault action setting
    logic [15:0] warn_q, warn_d; // Warning threshold
    logic [15:0] unit_q, unit_d; // Delay unit setting
    logic ack_d;
    logic [15:0] rdata_d;

    // Sequencer
    ovr_state_type state_q, state_d;
    logic [31:0] timer_q, timer_d; // Cycles since attempt or detection
    logic [2:0] left_q, left_d; // Restarts still allowed
    logic en_d, latched_d, warn_flag_d;

    // Derived signals
    logic fault; // Synchronised fault level
    logic on_cmd; // Output commanded on
    logic [31:0] unit_cycles; // One delay unit in cycles
    logic [31:0] delay_cycles; // Full delay in cycles
    logic delay_done;

    assign fault = fault_sync_q[1];
    assign on_cmd = ctrl_sync_q[1] & op_on;
    // Unit scales the base by value + 1 so a zero setting is never zero time
    assign unit_cycles = (32'(unit_q) + 32'h1) * 32'(UNIT_BASE_CYCLES);
    assign delay_cycles = unit_cycles << resp_q.delay;
    assign delay_done = (timer_q + 32'h1) >= delay_cycles;

    // Pin synchronisers: first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (srst) begin
            fault_sync_q <= 2'h0;
            ctrl_sync_q <= 2'h0;
        end else begin
            fault_sync_q <= {fault_sync_q[0], ov_fault_pin};
            ctrl_sync_q <= {ctrl_sync_q[0], ctrl_pin};
        end
    end

    // Register writes and read answers
    always_comb begin
        resp_d = resp_q;
        warn_d = warn_q;
        unit_d = unit_q;
        ack_d = cmd_valid;
        rdata_d = 16'h0000;
        if (cmd_valid && cmd_write) begin
            unique case (cmd_code)
                CMD_OV_RESPONSE: resp_d = ovr_resp_type'(cmd_wdata[7:0]);
                CMD_OV_WARN: warn_d = cmd_wdata;
                CMD_UNIT: unit_d = cmd_wdata;
                default: ; // Status and unmapped codes ignore writes
            endcase
        end else if (cmd_valid) begin
            unique case (cmd_code)
                CMD_OV_RESPONSE: rdata_d = {8'h00, resp_q};
                CMD_OV_WARN: rdata_d = warn_q;
                CMD_UNIT: rdata_d = unit_q;
                CMD_OV_STATUS: begin
                    rdata_d[STAT_WARN_BIT] = ov_warn_q;
                    rdata_d[STAT_LATCH_BIT] = ov_latched_q;
                    rdata_d[STAT_OFF_BIT] = ~output_en_q;
                end
                default: rdata_d = 16'h0000; // Unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            resp_q <= ovr_resp_type'(RST_RESPONSE);
            warn_q <= RST_WARN;
            unit_q <= RST_UNIT;
            cmd_ack_q <= 1'b0;
            cmd_rdata_q <= 16'h0000;
        end else begin
            resp_q <= resp_d;
            warn_q <= warn_d;
            unit_q <= unit_d;
            cmd_ack_q <= ack_d;
            cmd_rdata_q <= rdata_d;
        end
    end

    // Fault sequencer next state
    always_comb begin
        state_d = state_q;
        timer_d = timer_q + 32'h1;
        left_d = left_q;
        unique case (state_q)
            ST_RUN: begin
                timer_d = 32'h0;
                left_d = resp_q.retries;
                if (fault && on_cmd) begin
                    unique case (resp_q.action)
                        ACT_IGNORE: state_d = ST_RUN;
                        ACT_RUN_THEN_RETRY: state_d = ST_GRACE;
                        ACT_SHUTDOWN_RETRY: state_d = (resp_q.retries == RETRY_NONE) ? ST_LATCH : ST_WAIT;
                        ACT_OFF_WHILE_FAULT: state_d = ST_HOLD;
                    endcase
                end
            end
            ST_GRACE: begin
                // Keep running through the delay, then judge the fault again
                if (!fault) begin
                    state_d = ST_RUN;
                end else if (delay_done) begin
                    timer_d = 32'h0;
                    state_d = (resp_q.retries == RETRY_NONE) ? ST_LATCH : ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (delay_done) begin
                    // Start of the next attempt restarts the spacing timer
                    timer_d = 32'h0;
                    state_d = ST_TRY;
                    if (resp_q.retries != RETRY_ENDLESS) begin
                        left_d = left_q - 3'h1;
                    end
                end
            end
            ST_TRY: begin
                if (fault) begin
                    // Failed attempt: stay off; timer keeps running so spacing is start to start
                    if (left_q == 3'h0 && resp_q.retries != RETRY_ENDLESS) begin
                        state_d = ST_LATCH;
                    end else begin
                        state_d = ST_WAIT;
                    end
                end else if (delay_done) begin
                    state_d = ST_RUN; // Attempt held a full delay: recovered
                end
            end
            ST_LATCH: begin
                timer_d = 32'h0;
                if (clear_faults) begin
                    state_d = ST_RUN;
                end
            end
            ST_HOLD: begin
                timer_d = 32'h0;
                if (!fault) begin
                    state_d = ST_RUN;
                end
            end
            default: state_d = ST_RUN; // Unused codes recover
        endcase
        // Commanding off clears any fault sequence
        if (!on_cmd) begin
            state_d = ST_RUN;
            timer_d = 32'h0;
        end else if (other_fault && (state_q == ST_WAIT || state_q == ST_TRY)) begin
            state_d = ST_LATCH;
        end
    end

    // Outputs follow the next state so they stand in flip-flops
    always_comb begin
        en_d = on_cmd && (state_d == ST_RUN || state_d == ST_GRACE || state_d == ST_TRY);
        latched_d = (state_d == ST_LATCH);
        // Warning only flags; it never touches the enable
        warn_flag_d = (vout_meas > warn_q);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= ST_RUN;
            timer_q <= 32'h0;
            left_q <= 3'h0;
            output_en_q <= 1'b0;
            ov_latched_q <= 1'b0;
            ov_warn_q <= 1'b0;
        end else begin
            state_q <= state_d;
            timer_q <= timer_d;
            left_q <= left_d;
            output_en_q <= en_d;
            ov_latched_q <= latched_d;
            ov_warn_q <= warn_flag_d;
        end
    end

endmodule

`default_nettype wire

//--- verif/ovr_fault_retry_asserts.sv
/*
  Port checker for the over-voltage retry block.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module ovr_fault_retry_asserts
    import ovr_pkg::*;
(
    input wire logic core_clk, // Clock
    input wire logic srst, // Reset
    input wire logic cmd_valid, // Strobe
    input wire logic cmd_write, // Write
    input wire logic [7:0] cmd_code, // Code
    input wire logic [15:0] cmd_wdata, // Data in
    input wire logic cmd_ack_q, // Answer
    input wire logic [15:0] cmd_rdata_q, // Data out
    input wire logic op_on, // On command
    input wire logic clear_faults, // Clear
    input wire logic [15:0] vout_meas, // Measured
    input wire logic output_en_q, // Enable
    input wire logic ov_latched_q, // Latched
    input wire logic ov_warn_q // Warning
);
    logic [15:0] thr_q; // Threshold shadow
    logic [7:0] rsp_q; // Action shadow
    // Shadows track writes so reads and flags have a reference
    always_ff @(posedge core_clk) begin
        if (srst) begin
            thr_q <= RST_WARN;
            rsp_q <= RST_RESPONSE;
        end else if (cmd_valid && cmd_write) begin
            thr_q <= (cmd_code == CMD_OV_WARN) ? cmd_wdata : thr_q;
            rsp_q <= (cmd_code == CMD_OV_RESPONSE) ? cmd_wdata[7:0] : rsp_q;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    a_ack_follows: assert property (cmd_valid |=> cmd_ack_q)
        else $error("no answer");
    a_thr_readback: assert property ($past(cmd_valid && !cmd_write && cmd_code == CMD_OV_WARN)
        |-> cmd_rdata_q == thr_q) else $error("bad threshold read");
    a_warn_level: assert property (ov_warn_q == $past(vout_meas > thr_q))
        else $error("bad warning");
    a_cmd_off: assert property (!op_on [*3] |-> !output_en_q)
        else $error("on while commanded off");
    a_latch_off: assert property (ov_latched_q |-> !output_en_q)
        else $error("on while latched");
    a_latch_holds: assert property (ov_latched_q && !clear_faults && op_on |=> ov_latched_q)
        else $error("latch left early");
    a_ignore_runs: assert property (rsp_q[7:6] == ACT_IGNORE && output_en_q && op_on |=> output_en_q)
        else $error("ignored fault dropped output");
    a_no_retry: assert property (rsp_q == RST_RESPONSE && $fell(output_en_q) && $past(op_on) && op_on
        |=> !output_en_q [*8]) else $error("restart without retries");
    c_latch: cover property ($rose(ov_latched_q));
    c_warn: cover property ($rose(ov_warn_q));
    c_endless: cover property ($rose(output_en_q) && rsp_q[5:3] == RETRY_ENDLESS);
endmodule
`default_nettype wire

//--- verif/ovr_host.sv
/*
  Host model on the decoded command port.
  Assumes the bench calls xfer one transfer at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module ovr_host (
    input wire logic core_clk, // Clock
    output logic cmd_valid, // Strobe
    output logic cmd_write, // Write
    output logic [7:0] cmd_code, // Code
    output logic [15:0] cmd_wdata, // Data out
    input wire logic cmd_ack_q, // Answer
    input wire logic [15:0] cmd_rdata_q // Data in
);
    initial {cmd_valid, cmd_write, cmd_code, cmd_wdata} = 26'h0;
    // Whole word per strobe; data inverted after release so nothing stale looks valid
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] wd,
        output logic [15:0] rd, output logic ok);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_code <= code;
        cmd_wdata <= wd;
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        cmd_wdata <= ~wd;
        ok = 1'b0;
        rd = 16'h0;
        for (int i = 0; i < 3 && !ok; i++) begin
            @(posedge core_clk);
            ok = cmd_ack_q;
            rd = cmd_rdata_q;
        end
    endtask
endmodule
`default_nettype wire

//--- verif/ovr_fault_retry_tb.sv
/*
  Bench for the retry block: registers, warning and retry runs.
  Assumes the host model and the checker bound below.
*/
`timescale 1ns/1ps
`default_nettype none
module ovr_fault_retry_tb;
    import ovr_pkg::*;
    logic core_clk, srst, cmd_valid, cmd_write, cmd_ack_q, ov_fault_pin, ok; // Bits
    logic ctrl_pin, op_on, clear_faults, other_fault, output_en_q, ov_latched_q, ov_warn_q; // Bits
    logic [7:0] cmd_code, r; // Code, action setting
    logic [15:0] cmd_wdata, cmd_rdata_q, vout_meas, rd, u; // Words
    integer seed = 17154; // Fixed seed
    int err_total, total_checks, rises; // Counters
    // Code 7 case reaches the longest delay of 128 units at the smallest unit
    logic [7:0] rt [10] = '{8'h80, 8'h98, 8'ha0, 8'ha8, 8'hb0, 8'h00, 8'hc0, 8'h48, 8'h97, 8'h90}; // Cases
    int nt [10] = '{0, 3, 4, 5, 6, 0, 0, 1, 2, 2}; // Restarts per case
    ovr_fault_retry dut (.*);
    ovr_host host (.*);
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // A missing answer counts as a mismatch, so no wait hangs
    task automatic bus(input logic wr, input logic [7:0] code, input logic [15:0] wd);
        host.xfer(wr, code, wd, rd, ok);
        chk({15'h0, ok}, 16'h1);
    endtask
    // Delay in cycles: unit setting plus one, times base, doubled per code step
    function automatic int span(input logic [15:0] un, input logic [2:0] code);
        return ((int'(un) + 1) * UNIT_BASE_CYCLES) << code;
    endfunction
    // Hold the fault, counting restarts and checking their spacing
    task automatic run(input int win);
        int last = -1;
        logic prev = output_en_q;
        bus(1'b1, CMD_UNIT, u);
        bus(1'b1, CMD_OV_RESPONSE, {8'h0, r});
        rises = 0;
        ov_fault_pin <= 1'b1;
        for (int c = 0; c < win; c++) begin
            @(posedge core_clk);
            if (output_en_q && !prev) begin
                if (last >= 0) chk(16'(c - last), 16'(span(u, r[2:0])));
                last = c;
                rises++;
            end
            prev = output_en_q;
        end
        ov_fault_pin <= 1'b0;
    endtask
    // Clear the latch and expect the output back
    task automatic settle();
        repeat (4) @(posedge core_clk);
        clear_faults <= 1'b1;
        @(posedge core_clk);
        clear_faults <= 1'b0;
        repeat (6) @(posedge core_clk);
        chk({15'h0, output_en_q}, 16'h1);
    endtask
    initial begin
        {srst, ctrl_pin, op_on} = 3'b111;
        {ov_fault_pin, clear_faults, other_fault, vout_meas, u} = 35'h0;
        repeat (5) @(posedge core_clk);
        srst <= 1'b0;
        bus(1'b0, CMD_OV_RESPONSE, 16'h0);
        chk(rd, {8'h0, RST_RESPONSE});
        bus(1'b0, CMD_OV_WARN, 16'h0);
        chk(rd, RST_WARN);
        bus(1'b0, CMD_UNIT, 16'h0);
        chk(rd, RST_UNIT);
        bus(1'b0, 8'h77, 16'h0);
        chk(rd, 16'h0);
        // Threshold zero first, then random; compare just above and at it
        for (int i = 0; i < 4; i++) begin
            u = (i == 0) ? 16'h0 : 16'($random(seed)) & 16'hfffe;
            bus(1'b1, CMD_OV_WARN, u);
            bus(1'b0, CMD_OV_WARN, 16'h0);
            chk(rd, u);
            vout_meas <= u + 16'h1;
            repeat (3) @(posedge core_clk);
            chk({14'h0, ov_warn_q, output_en_q}, 16'h3);
            // Status byte mirrors the warning while the output stays on
            bus(1'b0, CMD_OV_STATUS, 16'h0);
            chk(rd, 16'h0001);
            vout_meas <= u;
            repeat (3) @(posedge core_clk);
            chk({14'h0, ov_warn_q, output_en_q}, 16'h1);
        end
        $display("test registers done");
        for (int k = 0; k < 10; k++) begin
            r = rt[k];
            u = 16'h0;
            if (k == 9) begin
                r[2:0] = 3'($unsigned($random(seed)) % 3);
                u = 16'($unsigned($random(seed)) % 2);
            end
            run(8 * span(u, r[2:0]) + 40);
            chk(16'(rises), 16'(nt[k]));
            chk({14'h0, output_en_q, ov_latched_q}, {14'h0, r[7:6] == ACT_IGNORE, r[7] != r[6]});
            settle();
        end
        $display("test retries done");
        r = 8'hb8;
        run(800);
        chk({15'h0, rises > 6}, 16'h1);
        op_on <= 1'b0;
        repeat (100) @(posedge core_clk);
        chk({14'h0, output_en_q, ov_latched_q}, 16'h0);
        bus(1'b0, CMD_OV_STATUS, 16'h0);
        chk(rd, 16'h0004);
        op_on <= 1'b1;
        settle();
        $display("test endless done");
        // Another fault during endless retries must latch the output off
        other_fault <= 1'b1;
        run(100);
        chk({14'h0, output_en_q, ov_latched_q}, 16'h1);
        chk(16'(rises), 16'h0);
        bus(1'b0, CMD_OV_STATUS, 16'h0);
        chk(rd, 16'h0006);
        other_fault <= 1'b0;
        settle();
        // Control pin off keeps the output down and blocks every restart
        ctrl_pin <= 1'b0;
        run(200);
        chk({14'h0, output_en_q, ov_latched_q}, 16'h0);
        chk(16'(rises), 16'h0);
        ctrl_pin <= 1'b1;
        settle();
        $display("test shutdown done");
        summarize();
    end
endmodule
bind ovr_fault_retry ovr_fault_retry_asserts chk_i (.*);
`default_nettype wire
